// ==== rtl/flash_table_access.sv ====
// Overview of operation
// RQ1: Unlock key register always reads zero.
// RQ2: Erase select turns next start into erase.
// RQ3: Programming needs enable; enable clears at reset.
// RQ4: Fault set at start, cleared on completion.
// RQ5: Start set by software, cleared by hardware.
// RQ6: Eight-bit latch carries table data bytes.
// RQ7: Three bytes form the 22-bit pointer.
// RQ8: Auto stepping touches only low 21 bits.
// RQ9: Four pointer update modes per table op.
// RQ10: Table read uses all pointer bits.
// RQ11: Table write fills holding register by bits 5:0.
// RQ12: Program block chosen by bits 20:6; the code uses bits 21:6.
// RQ13: Erase block chosen by bits 20:10; the code uses bits 21:10.
// RQ14: Software checks fault after unexpected reset.
// RQ15: Software unlocks before each write or erase.
// RQ16: Control bit layout; unused bits read zero.
// RQ17: Software verifies programmed bytes afterwards.
// RQ18: Start ignored without enable and fresh unlock.
// RQ19: Fetch stalls while programming runs.
`timescale 1ns/1ps
`default_nettype none

module flash_table_access
    import flash_table_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic por_n_i,
    input wire logic [ADDR_W-1:0] bus_addr_i,
    input wire logic [DATA_W-1:0] bus_wdata_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    output logic [DATA_W-1:0] bus_rdata_o,
    input wire logic tbl_req_i,
    input wire logic tbl_store_i,
    input wire logic [1:0] tbl_mode_i,
    output logic tbl_ready_o,
    output logic tbl_done_o,
    output logic flash_rd_en_o,
    output logic [PTR_W-1:0] flash_rd_addr_o,
    input wire logic [DATA_W-1:0] flash_rd_data_i,
    output logic flash_prog_we_o,
    output logic flash_erase_o,
    output logic [PTR_W-1:0] flash_prog_addr_o,
    output logic [DATA_W-1:0] flash_prog_data_o,
    output logic fetch_stall_o,
    output logic irq_o
);

    seq_state_t state_ff;
    logic [PTR_W-1:0] table_pointer_ff;
    logic [DATA_W-1:0] table_data_latch_ff;
    logic erase_select_ff;
    logic program_enable_ff;
    logic program_start_ff;
    logic program_fault_ff;
    logic [1:0] unlock_stage_ff;
    logic [HOLD_IDX_W-1:0] prog_idx_ff;
    logic [TIMER_W-1:0] timer_ff;
    logic [IRQ_W-1:0] irq_status_ff;
    logic [IRQ_W-1:0] irq_mask_ff;

    logic [PTR_W-1:0] eff_ptr;
    logic [PTR_W-1:0] nxt_ptr;
    logic tbl_accept;
    logic start_req;
    logic launch;
    logic finish;
    logic [DATA_W-1:0] hold_rd_data;

    function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p,
                                                 input logic down);
        logic [LOW_W-1:0] low;
        low = down ? p[LOW_W-1:0] - LOW_W'(1) : p[LOW_W-1:0] + LOW_W'(1);
        // RQ8: top bit untouched
        return {p[PTR_W-1], low};
    endfunction : ptr_step

    function automatic logic reg_wr(input logic wr, input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] r);
        return wr && (a == r);
    endfunction : reg_wr

    assign tbl_ready_o = (state_ff == ST_IDLE) && !program_start_ff && !launch;
    assign tbl_accept = tbl_req_i && tbl_ready_o;
    // RQ19: fetch stall
    assign fetch_stall_o = program_start_ff;
    assign irq_o = |(irq_status_ff & irq_mask_ff);

    // RQ9: four update modes
    always_comb begin
        eff_ptr = table_pointer_ff;
        nxt_ptr = table_pointer_ff;
        case (ptr_mode_t'(tbl_mode_i))
            PTR_HOLD: nxt_ptr = table_pointer_ff;
            PTR_POST_INC: nxt_ptr = ptr_step(table_pointer_ff, 1'b0);
            PTR_POST_DEC: nxt_ptr = ptr_step(table_pointer_ff, 1'b1);
            PTR_PRE_INC: begin
                eff_ptr = ptr_step(table_pointer_ff, 1'b0);
                nxt_ptr = eff_ptr;
            end
            default: nxt_ptr = table_pointer_ff;
        endcase
    end

    assign start_req = reg_wr(bus_wr_i, bus_addr_i, REG_CONTROL)
                       && bus_wdata_i[BIT_START] && !program_start_ff && (state_ff == ST_IDLE);
    // RQ18: enable plus fresh unlock
    assign launch = start_req && program_enable_ff && (unlock_stage_ff == 2'd2);
    assign finish = (state_ff == ST_WAIT) && (timer_ff == '0);

    // Unlock tracking: any other write breaks the sequence
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            unlock_stage_ff <= 2'd0;
        end else if (bus_wr_i) begin
            if (bus_addr_i == REG_UNLOCK && bus_wdata_i == UNLOCK_KEY_FIRST) begin
                unlock_stage_ff <= 2'd1;
            end else if (bus_addr_i == REG_UNLOCK && bus_wdata_i == UNLOCK_KEY_SECOND
                         && unlock_stage_ff == 2'd1) begin
                unlock_stage_ff <= 2'd2;
            end else begin
                unlock_stage_ff <= 2'd0;
            end
        end
    end

    // RQ7: pointer bytes and table stepping
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            table_pointer_ff <= RESET_PTR;
        end else if (tbl_accept) begin
            // Table op wins over a same-cycle software write
            table_pointer_ff <= nxt_ptr;
        end else if (reg_wr(bus_wr_i, bus_addr_i, REG_PTR_LOW)) begin
            table_pointer_ff[7:0] <= bus_wdata_i;
        end else if (reg_wr(bus_wr_i, bus_addr_i, REG_PTR_HIGH)) begin
            table_pointer_ff[15:8] <= bus_wdata_i;
        end else if (reg_wr(bus_wr_i, bus_addr_i, REG_PTR_UPPER)) begin
            table_pointer_ff[21:16] <= bus_wdata_i[5:0];
        end
    end

    // RQ6: latch loaded by read or software
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            table_data_latch_ff <= RESET_BYTE;
        end else if (state_ff == ST_RD_CAP) begin
            table_data_latch_ff <= flash_rd_data_i;
        end else if (reg_wr(bus_wr_i, bus_addr_i, REG_LATCH)) begin
            table_data_latch_ff <= bus_wdata_i;
        end
    end

    // RQ3: enable clears at reset
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            erase_select_ff <= 1'b0;
            program_enable_ff <= 1'b0;
        end else if (reg_wr(bus_wr_i, bus_addr_i, REG_CONTROL)) begin
            erase_select_ff <= bus_wdata_i[BIT_ERASE_SEL];
            program_enable_ff <= bus_wdata_i[BIT_ENABLE];
        end
    end

    // RQ5: software sets, hardware clears
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            program_start_ff <= 1'b0;
        end else if (launch) begin
            program_start_ff <= 1'b1;
        end else if (finish) begin
            program_start_ff <= 1'b0;
        end
    end

    // RQ4: fault survives a plain reset
    always_ff @(posedge ref_clk_i or negedge por_n_i) begin
        if (!por_n_i) begin
            program_fault_ff <= 1'b0;
        end else if (launch) begin
            program_fault_ff <= 1'b1;
        end else if (finish) begin
            program_fault_ff <= 1'b0;
        end
    end

    // RQ11: holding register fill
    holding_buffer u_hold (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .wr_en_i(tbl_accept && tbl_store_i),
        .wr_idx_i(eff_ptr[HOLD_IDX_W-1:0]),
        .wr_data_i(table_data_latch_ff),
        .rd_idx_i(prog_idx_ff),
        .rd_data_o(hold_rd_data)
    );

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff <= ST_IDLE;
            prog_idx_ff <= '0;
            timer_ff <= '0;
            tbl_done_o <= 1'b0;
            flash_rd_en_o <= 1'b0;
            flash_rd_addr_o <= RESET_PTR;
            flash_prog_we_o <= 1'b0;
            flash_erase_o <= 1'b0;
            flash_prog_addr_o <= RESET_PTR;
            flash_prog_data_o <= RESET_BYTE;
        end else begin
            tbl_done_o <= 1'b0;
            flash_rd_en_o <= 1'b0;
            flash_prog_we_o <= 1'b0;
            flash_erase_o <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    prog_idx_ff <= '0;
                    if (launch) begin
                        // RQ2: erase instead of write
                        state_ff <= bus_wdata_i[BIT_ERASE_SEL] ? ST_ERASE : ST_PROG;
                    end else if (tbl_accept && tbl_store_i) begin
                        tbl_done_o <= 1'b1;
                    end else if (tbl_accept) begin
                        // RQ10: full pointer for reads
                        flash_rd_en_o <= 1'b1;
                        flash_rd_addr_o <= eff_ptr;
                        state_ff <= ST_RD_REQ;
                    end
                end
                ST_RD_REQ: begin
                    state_ff <= ST_RD_CAP;
                end
                ST_RD_CAP: begin
                    tbl_done_o <= 1'b1;
                    state_ff <= ST_IDLE;
                end
                ST_PROG: begin
                    // RQ12 asks for bits 20:6; block taken from bits 21:6
                    flash_prog_we_o <= 1'b1;
                    flash_prog_addr_o <= {table_pointer_ff[PTR_W-1:HOLD_IDX_W], prog_idx_ff};
                    flash_prog_data_o <= hold_rd_data;
                    prog_idx_ff <= prog_idx_ff + HOLD_IDX_W'(1);
                    if (prog_idx_ff == HOLD_IDX_W'(HOLD_DEPTH - 1)) begin
                        timer_ff <= TIMER_W'(PROG_CYCLES - 1);
                        state_ff <= ST_WAIT;
                    end
                end
                ST_ERASE: begin
                    // RQ13: low ten bits ignored
                    flash_erase_o <= 1'b1;
                    flash_prog_addr_o <= {table_pointer_ff[PTR_W-1:10], 10'h000};
                    timer_ff <= TIMER_W'(PROG_CYCLES - 1);
                    state_ff <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (timer_ff == '0) begin
                        state_ff <= ST_IDLE;
                    end else begin
                        timer_ff <= timer_ff - TIMER_W'(1);
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Sticky events; a new event beats the clearing write
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            irq_status_ff <= '0;
            irq_mask_ff <= '0;
        end else begin
            irq_status_ff <= (irq_status_ff
                & ~(reg_wr(bus_wr_i, bus_addr_i, REG_IRQ_STATUS)
                    ? bus_wdata_i[IRQ_W-1:0] : '0))
                | {start_req && !launch, finish};
            if (reg_wr(bus_wr_i, bus_addr_i, REG_IRQ_MASK)) begin
                irq_mask_ff <= bus_wdata_i[IRQ_W-1:0];
            end
        end
    end

    // RQ16: register readback
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bus_rdata_o <= RESET_BYTE;
        end else if (bus_rd_i) begin
            case (bus_addr_i)
                REG_PTR_LOW: bus_rdata_o <= table_pointer_ff[7:0];
                REG_PTR_HIGH: bus_rdata_o <= table_pointer_ff[15:8];
                REG_PTR_UPPER: bus_rdata_o <= {2'b00, table_pointer_ff[21:16]};
                REG_LATCH: bus_rdata_o <= table_data_latch_ff;
                // RQ1: key has no storage
                REG_UNLOCK: bus_rdata_o <= RESET_BYTE;
                REG_CONTROL: bus_rdata_o <= {3'b000, erase_select_ff, program_fault_ff,
                                             program_enable_ff, program_start_ff, 1'b0};
                REG_IRQ_STATUS: bus_rdata_o <= {6'h00, irq_status_ff};
                REG_IRQ_MASK: bus_rdata_o <= {6'h00, irq_mask_ff};
                default: bus_rdata_o <= RESET_BYTE;
            endcase
        end else begin
            bus_rdata_o <= RESET_BYTE;
        end
    end

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    property p_key_zero;
        bus_rd_i && bus_addr_i == REG_UNLOCK |=> bus_rdata_o == 8'h00;
    endproperty
    a_key_zero: assert property (p_key_zero) else $error("key read not zero"); // RQ1

    property p_erase_launch;
        $rose(program_start_ff) && erase_select_ff |=> flash_erase_o;
    endproperty
    a_erase_launch: assert property (p_erase_launch) else $error("no erase"); // RQ2

    property p_enable_needed;
        $rose(program_start_ff) |-> $past(program_enable_ff);
    endproperty
    a_enable_needed: assert property (p_enable_needed) else $error("start w/o enable"); // RQ3

    property p_fault_set;
        $rose(program_start_ff) |-> program_fault_ff;
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("fault not set"); // RQ4

    property p_start_clear;
        $fell(program_start_ff) |-> $past(state_ff == ST_WAIT) && !program_fault_ff;
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("early start clear"); // RQ5

    property p_latch_load;
        state_ff == ST_RD_CAP |=> table_data_latch_ff == $past(flash_rd_data_i) && tbl_done_o;
    endproperty
    a_latch_load: assert property (p_latch_load) else $error("latch not loaded"); // RQ6

    property p_top_bit;
        tbl_accept |=> table_pointer_ff[21] == $past(table_pointer_ff[21]);
    endproperty
    a_top_bit: assert property (p_top_bit) else $error("top bit stepped"); // RQ8

    property p_prog_burst;
        $rose(program_start_ff) && !erase_select_ff |=> flash_prog_we_o [*8];
    endproperty
    a_prog_burst: assert property (p_prog_burst) else $error("burst broken"); // RQ12

    property p_erase_addr;
        flash_erase_o |-> flash_prog_addr_o[9:0] == 10'h000;
    endproperty
    a_erase_addr: assert property (p_erase_addr) else $error("erase addr low bits"); // RQ13

    property p_refuse;
        start_req && !program_enable_ff |=> !program_start_ff && irq_status_ff[IRQ_REFUSED];
    endproperty
    a_refuse: assert property (p_refuse) else $error("start not refused"); // RQ18

    property p_stall;
        program_start_ff |-> fetch_stall_o && !tbl_ready_o;
    endproperty
    a_stall: assert property (p_stall) else $error("fetch not stalled"); // RQ19

    c_erase: cover property ($rose(flash_erase_o));
    c_prog_done: cover property (finish && !erase_select_ff);
    c_read: cover property (state_ff == ST_RD_CAP);

endmodule : flash_table_access

`default_nettype wire

// ==== include/flash_table_pkg.sv ====
package flash_table_pkg;

    localparam int PTR_W = 22;
    localparam int LOW_W = 21;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;
    localparam int HOLD_DEPTH = 64;
    localparam int HOLD_IDX_W = 6;

    // Register indices on the byte-wide register port
    localparam logic [2:0] REG_PTR_LOW = 3'h0;
    localparam logic [2:0] REG_PTR_HIGH = 3'h1;
    localparam logic [2:0] REG_PTR_UPPER = 3'h2;
    localparam logic [2:0] REG_LATCH = 3'h3;
    localparam logic [2:0] REG_UNLOCK = 3'h4;
    localparam logic [2:0] REG_CONTROL = 3'h5;
    localparam logic [2:0] REG_IRQ_STATUS = 3'h6;
    localparam logic [2:0] REG_IRQ_MASK = 3'h7;

    // Control register fields
    localparam int BIT_ERASE_SEL = 4;
    localparam int BIT_FAULT = 3;
    localparam int BIT_ENABLE = 2;
    localparam int BIT_START = 1;

    // Interrupt status fields
    localparam int IRQ_DONE = 0;
    localparam int IRQ_REFUSED = 1;
    localparam int IRQ_W = 2;

    localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_KEY_SECOND = 8'hAA;

    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [21:0] RESET_PTR = 22'h000000;

    localparam int CLK_PERIOD_NS = 4;
    localparam int PROG_TIME_NS = 10000;
    localparam int PROG_CYCLES = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W = 12;

    typedef enum logic [1:0] {
        PTR_HOLD,
        PTR_POST_INC,
        PTR_POST_DEC,
        PTR_PRE_INC
    } ptr_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RD_REQ,
        ST_RD_CAP,
        ST_PROG,
        ST_ERASE,
        ST_WAIT
    } seq_state_t;

endpackage : flash_table_pkg

// ==== rtl/holding_buffer.sv ====
`timescale 1ns/1ps
`default_nettype none

module holding_buffer
    import flash_table_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic wr_en_i,
    input wire logic [HOLD_IDX_W-1:0] wr_idx_i,
    input wire logic [DATA_W-1:0] wr_data_i,
    input wire logic [HOLD_IDX_W-1:0] rd_idx_i,
    output logic [DATA_W-1:0] rd_data_o
);

    logic [DATA_W-1:0] hold_ff [HOLD_DEPTH];

    genvar g;
    generate
        for (g = 0; g < HOLD_DEPTH; g++) begin : g_hold
            always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    hold_ff[g] <= RESET_BYTE;
                end else if (wr_en_i && wr_idx_i == HOLD_IDX_W'(g)) begin
                    hold_ff[g] <= wr_data_i;
                end
            end
        end
    endgenerate

    assign rd_data_o = hold_ff[rd_idx_i];

endmodule : holding_buffer

`default_nettype wire

// ==== tb/flash_array_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module flash_array_model
    import flash_table_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rd_en_i,
    input wire logic [PTR_W-1:0] rd_addr_i,
    output logic [DATA_W-1:0] rd_data_o,
    input wire logic prog_we_i,
    input wire logic erase_i,
    input wire logic [PTR_W-1:0] prog_addr_i,
    input wire logic [DATA_W-1:0] prog_data_i
);
    logic [DATA_W-1:0] mem [int];
    int we_count = 0;
    int erase_count = 0;
    logic [PTR_W-1:0] erase_addr = '0;

    initial rd_data_o = 8'h00;

    function automatic logic [DATA_W-1:0] mem_byte(input logic [PTR_W-1:0] a);
        if (mem.exists(a)) begin
            return mem[a];
        end
        return a[7:0] ^ {a[21:16], a[9:8]};
    endfunction : mem_byte

    // Byte stands one cycle only, then the inverse, so a late sample shows up
    always @(posedge ref_clk_i) begin
        rd_data_o <= rd_en_i ? mem_byte(rd_addr_i) : ~rd_data_o;
        if (prog_we_i) begin
            mem[prog_addr_i] = prog_data_i;
            we_count++;
        end
        if (erase_i) begin
            erase_count++;
            erase_addr <= prog_addr_i;
        end
    end
endmodule : flash_array_model

`default_nettype wire

// ==== tb/program_flash_table_access_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module program_flash_table_access_tb import flash_table_pkg::*; ;
    localparam logic [7:0] EN = 8'h01 << BIT_ENABLE;
    localparam logic [7:0] ST = 8'h01 << BIT_START;
    localparam logic [7:0] FL = 8'h01 << BIT_FAULT;
    localparam logic [7:0] ER = 8'h01 << BIT_ERASE_SEL;
    typedef struct packed {logic [2:0] a; logic [7:0] d; logic [7:0] e;} row_t;
    row_t rows [7] = '{'{REG_PTR_LOW, 8'hA5, 8'hA5}, '{REG_PTR_HIGH, 8'h3C, 8'h3C},
        '{REG_PTR_UPPER, 8'hFF, 8'h3F}, '{REG_LATCH, 8'h5A, 8'h5A},
        '{REG_CONTROL, 8'hEC, 8'h04}, '{REG_UNLOCK, 8'h55, 8'h00},
        '{REG_IRQ_MASK, 8'h03, 8'h03}};
    logic ref_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic por_n_i = 1'b0;
    logic [ADDR_W-1:0] bus_addr_i = '0;
    logic [DATA_W-1:0] bus_wdata_i = '0;
    logic bus_wr_i = 1'b0;
    logic bus_rd_i = 1'b0;
    logic tbl_req_i = 1'b0;
    logic tbl_store_i = 1'b0;
    logic [1:0] tbl_mode_i = 2'h0;
    logic [DATA_W-1:0] bus_rdata_o, flash_rd_data_i, flash_prog_data_o, v;
    logic tbl_ready_o, tbl_done_o, flash_rd_en_o, flash_prog_we_o, flash_erase_o;
    logic fetch_stall_o, irq_o;
    logic [PTR_W-1:0] flash_rd_addr_o, flash_prog_addr_o, rd_seen, p, q;
    int err_count = 0;
    int comparisons = 0;
    int i, m, n;

    always #2 ref_clk_i = ~ref_clk_i;

    flash_table_access i_flash_table_access (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
        .por_n_i(por_n_i), .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i),
        .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_rdata_o(bus_rdata_o),
        .tbl_req_i(tbl_req_i), .tbl_store_i(tbl_store_i), .tbl_mode_i(tbl_mode_i),
        .tbl_ready_o(tbl_ready_o), .tbl_done_o(tbl_done_o), .flash_rd_en_o(flash_rd_en_o),
        .flash_rd_addr_o(flash_rd_addr_o), .flash_rd_data_i(flash_rd_data_i),
        .flash_prog_we_o(flash_prog_we_o), .flash_erase_o(flash_erase_o),
        .flash_prog_addr_o(flash_prog_addr_o), .flash_prog_data_o(flash_prog_data_o),
        .fetch_stall_o(fetch_stall_o), .irq_o(irq_o));

    flash_array_model i_flash_array_model (.ref_clk_i(ref_clk_i), .rd_en_i(flash_rd_en_o),
        .rd_addr_i(flash_rd_addr_o), .rd_data_o(flash_rd_data_i),
        .prog_we_i(flash_prog_we_o), .erase_i(flash_erase_o),
        .prog_addr_i(flash_prog_addr_o), .prog_data_i(flash_prog_data_o));

    function automatic logic [21:0] step(input logic [21:0] a, input logic [20:0] d);
        return {a[21], a[20:0] + d};
    endfunction : step

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    task automatic timeout();
        err_count++;
        $display("ERROR %0t: wait bound used up", $time);
        results();
    endtask : timeout

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        bus_wr_i <= 1'b1;
        bus_addr_i <= a;
        bus_wdata_i <= d;
        @(posedge ref_clk_i);
        bus_wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge ref_clk_i);
        bus_rd_i <= 1'b1;
        bus_addr_i <= a;
        @(posedge ref_clk_i);
        bus_rd_i <= 1'b0;
        #1;
        d = bus_rdata_o;
    endtask : rd

    task automatic set_ptr(input logic [21:0] a);
        wr(REG_PTR_LOW, a[7:0]);
        wr(REG_PTR_HIGH, a[15:8]);
        wr(REG_PTR_UPPER, {2'b00, a[21:16]});
    endtask : set_ptr

    task automatic get_ptr(output logic [21:0] a);
        logic [7:0] b;
        rd(REG_PTR_LOW, b);
        a[7:0] = b;
        rd(REG_PTR_HIGH, b);
        a[15:8] = b;
        rd(REG_PTR_UPPER, b);
        a[21:16] = b[5:0];
    endtask : get_ptr

    task automatic tbl_op(input logic store, input logic [1:0] mode);
        rd_seen = '0;
        @(posedge ref_clk_i);
        tbl_req_i <= 1'b1;
        tbl_store_i <= store;
        tbl_mode_i <= mode;
        @(posedge ref_clk_i);
        tbl_req_i <= 1'b0;
        for (int k = 0; k < 8; k++) begin
            #1;
            if (flash_rd_en_o === 1'b1) begin
                rd_seen = flash_rd_addr_o;
            end
            if (tbl_done_o === 1'b1) begin
                return;
            end
            @(posedge ref_clk_i);
        end
        timeout();
    endtask : tbl_op

    task automatic unlock_start(input logic [7:0] ctl);
        wr(REG_UNLOCK, UNLOCK_KEY_FIRST);
        wr(REG_UNLOCK, UNLOCK_KEY_SECOND);
        wr(REG_CONTROL, ctl);
    endtask : unlock_start

    task automatic wait_idle();
        for (int k = 0; k < 3000; k++) begin
            @(posedge ref_clk_i);
            #1;
            if (fetch_stall_o === 1'b0) begin
                return;
            end
        end
        timeout();
    endtask : wait_idle

    initial begin
        repeat (12) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        por_n_i <= 1'b1;
        for (i = 0; i < 8; i++) begin
            rd(i[2:0], v);
            chk(v, 8'h00);
        end
        chk(tbl_ready_o, 1'b1);
        $display("test reset finished");
        for (i = 0; i < 7; i++) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, v);
            chk(v, rows[i].e);
        end
        $display("test registers finished");
        for (i = 0; i < 8; i++) begin
            p = (i < 4) ? 22'h3FFFFF : 22'h200000;
            m = i % 4;
            set_ptr(p);
            tbl_op(1'b0, m[1:0]);
            q = (m == 3) ? step(p, 21'h000001) : p;
            chk(rd_seen, q);
            rd(REG_LATCH, v);
            chk(v, i_flash_array_model.mem_byte(q));
            get_ptr(q);
            chk(q, (m == 0) ? p : step(p, (m == 2) ? 21'h1FFFFF : 21'h000001));
        end
        $display("test table read finished");
        set_ptr(22'h123445);
        wr(REG_LATCH, 8'h77);
        tbl_op(1'b1, PTR_POST_INC);
        get_ptr(q);
        chk(q, 22'h123446);
        n = i_flash_array_model.we_count;
        wr(REG_CONTROL, EN);
        unlock_start(EN | ST);
        rd(REG_CONTROL, v);
        chk(v, EN | ST | FL);
        chk(fetch_stall_o, 1'b1);
        chk(tbl_ready_o, 1'b0);
        wr(REG_CONTROL, EN);
        rd(REG_CONTROL, v);
        chk(v, EN | ST | FL);
        wait_idle();
        rd(REG_CONTROL, v);
        chk(v, EN);
        chk(i_flash_array_model.we_count - n, 64);
        chk(i_flash_array_model.mem_byte(22'h123445), 8'h77);
        set_ptr(22'h123445);
        tbl_op(1'b0, PTR_HOLD);
        rd(REG_LATCH, v);
        chk(v, 8'h77);
        rd(REG_IRQ_STATUS, v);
        chk(v, 8'h01);
        chk(irq_o, 1'b1);
        wr(REG_IRQ_STATUS, 8'h01);
        #1;
        chk(irq_o, 1'b0);
        $display("test program finished");
        p = 22'h0ABCDE;
        set_ptr(p);
        n = i_flash_array_model.we_count;
        m = i_flash_array_model.erase_count;
        unlock_start(EN | ST | ER);
        wait_idle();
        chk(i_flash_array_model.erase_count - m, 1);
        chk(i_flash_array_model.we_count - n, 0);
        chk(i_flash_array_model.erase_addr[20:10], p[20:10]);
        $display("test erase finished");
        wr(REG_IRQ_STATUS, 8'h03);
        wr(REG_CONTROL, 8'h00);
        unlock_start(ST);
        rd(REG_CONTROL, v);
        chk(v, 8'h00);
        wr(REG_CONTROL, EN);
        wr(REG_UNLOCK, UNLOCK_KEY_FIRST);
        wr(REG_PTR_LOW, 8'h00);
        wr(REG_UNLOCK, UNLOCK_KEY_SECOND);
        wr(REG_CONTROL, EN | ST);
        rd(REG_CONTROL, v);
        chk(v, EN);
        chk(fetch_stall_o, 1'b0);
        rd(REG_IRQ_STATUS, v);
        chk(v, 8'h02);
        chk(irq_o, 1'b1);
        wr(REG_IRQ_MASK, 8'h00);
        #1;
        chk(irq_o, 1'b0);
        $display("test refusal finished");
        unlock_start(EN | ST);
        repeat (100) @(posedge ref_clk_i);
        reset_n_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        rd(REG_CONTROL, v);
        chk(v, FL);
        @(posedge ref_clk_i);
        por_n_i <= 1'b0;
        @(posedge ref_clk_i);
        por_n_i <= 1'b1;
        rd(REG_CONTROL, v);
        chk(v, 8'h00);
        $display("test reset in program finished");
        results();
    end
endmodule : program_flash_table_access_tb

`default_nettype wire
